// [hdl/mps_serial.sv]
// Multiprocessor asynchronous serial port with APB registers
// Operation
// RULE1: Mode bit picks idle-line or address-bit
// RULE2: Ten idle bit times mark block start
// RULE3: Address frame wakes, requests receive interrupt
// RULE4: Sleeping receiver shifts but sets no flags
// RULE5: Software compares address, clears sleep on match
// RULE6: Sender may leave ten-bit gap itself
// RULE7: Software sets wake, writes dummy, then address
// RULE8: Wake frame sends eleven idle bits instead
// RULE9: Load copies wake to latch, clears request
// RULE10: Buffer free once word enters shift register
// RULE11: Address mode adds address bit after data
// RULE12: Latched wake value becomes sent address bit
// RULE13: Address mode ignores idle gaps
// RULE14: Software sets wake only for address frames
// RULE15: Start, one-eight data, parity, one-two stops
// RULE16: Each bit spans eight sample ticks
// RULE17: Start needs four zero ticks, else rehunt
// RULE18: Majority of ticks four, five, six
// RULE19: Idle-line mode suits point-to-point links
// RULE20: Hardware never changes the sleep bit
// RULE21: Address mode wakes only on address bit one
// RULE22: Parity select zero odd, one even
// RULE23: Receiver rehunts after stop, idle line high
// RULE24: First frame after gap is address frame
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_serial (
    input wire logic clock_i,           // System clock, 40 MHz
    input wire logic srst_i,            // Synchronous reset, active high
    input wire logic psel_i,            // APB select
    input wire logic penable_i,         // APB enable
    input wire logic pwrite_i,          // APB write
    input wire logic [7:0] paddr_i,     // APB byte address
    input wire logic [31:0] pwdata_i,   // APB write data
    output logic [31:0] prdata_o,       // APB read data
    output logic pready_o,              // APB ready
    output logic pslverr_o,             // APB error on unmapped address
    input wire logic rxd_i,             // Serial receive line
    output logic txd_o,                 // Serial transmit line
    output logic rx_irq_o,              // Receive interrupt request
    output logic tx_irq_o               // Transmit interrupt request
);
    localparam logic [2:0] PH_LAST = 3'(`MPS_BIT_TICKS - 1);
    localparam logic [2:0] PH_START = 3'(`MPS_START_TICKS - 1);
    localparam logic [6:0] GAP_TICKS = 7'(`MPS_GAP_BITS * `MPS_BIT_TICKS);

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    wire acc = psel_i & penable_i;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire hit_ccr = (paddr_i == `MPS_OFS_CCR);
    wire hit_ctl1 = (paddr_i == `MPS_OFS_CTL1);
    wire hit_baud = (paddr_i == `MPS_OFS_BAUD);
    wire hit_ctl2 = (paddr_i == `MPS_OFS_CTL2);
    wire hit_rxst = (paddr_i == `MPS_OFS_RXST);
    wire hit_rxbuf = (paddr_i == `MPS_OFS_RXBUF);
    wire hit_txbuf = (paddr_i == `MPS_OFS_TXBUF);
    wire mapped = hit_ccr | hit_ctl1 | hit_baud | hit_ctl2 | hit_rxst
                | hit_rxbuf | hit_txbuf;
    wire wr_ccr = wr & hit_ccr;
    wire wr_ctl1 = wr & hit_ctl1;
    wire wr_baud = wr & hit_baud;
    wire wr_ctl2 = wr & hit_ctl2;
    wire wr_rxst = wr & hit_rxst;
    wire wr_txbuf = wr & hit_txbuf;
    wire rd_rxbuf = rd & hit_rxbuf;

    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] comm_control_reg_q;
    logic rx_en_q;
    logic tx_en_q;
    logic sleep_q;
    logic tx_wake_request_q;
    logic rx_err_irq_en_q;
    logic [15:0] baud_q;
    logic tx_irq_en_q;
    logic rx_break_irq_enable_q;
    logic rx_wake_flag_q;
    logic par_err_q;
    logic ovr_err_q;
    logic frm_err_q;
    logic rx_char_ready_q;
    logic [7:0] rx_buf_q;
    logic [7:0] tx_buffer_reg_q;
    logic tx_full_q;

    wire addr_mode = comm_control_reg_q[`MPS_CCR_MODE];  // RULE1
    wire par_en = comm_control_reg_q[`MPS_CCR_PEN];
    wire par_even = comm_control_reg_q[`MPS_CCR_EVEN];
    wire [2:0] char_code = comm_control_reg_q[2:0];
    wire rx_err = par_err_q | ovr_err_q | frm_err_q;

    wire [7:0] ctl1_rd = {1'b0, rx_err_irq_en_q, 2'b00, tx_wake_request_q,
                          sleep_q, tx_en_q, rx_en_q};
    wire [7:0] ctl2_rd;
    wire [7:0] rxst_rd = {rx_err, rx_char_ready_q, 1'b0, frm_err_q,
                          ovr_err_q, par_err_q, rx_wake_flag_q, 1'b0};
    wire [15:0] rd_mux = hit_ccr ? {8'h00, comm_control_reg_q}
                       : hit_ctl1 ? {8'h00, ctl1_rd}
                       : hit_baud ? baud_q
                       : hit_ctl2 ? {8'h00, ctl2_rd}
                       : hit_rxst ? {8'h00, rxst_rd}
                       : hit_rxbuf ? {8'h00, rx_buf_q}
                       : 16'h0000;
    assign prdata_o = rd ? {16'h0000, rd_mux} : 32'h0000_0000;

    // ****************************************************************
    // Sample tick divider
    // ****************************************************************
    logic [15:0] div_q;
    wire sample_clock_tick = (div_q == 16'h0000);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            div_q <= `MPS_BAUD_RST;
        end else begin
            div_q <= sample_clock_tick ? baud_q : div_q - 16'd1;
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    mps_pkg::mps_rx_state_t rx_state_q;
    logic [2:0] rx_ph_q;
    logic [3:0] rx_idx_q;
    logic [10:0] rx_frame_q;
    logic [1:0] votes_q;
    logic [6:0] idle_cnt_q;
    logic gap_seen_q;

    wire [3:0] len = {1'b0, char_code} + 4'd1;
    wire [3:0] pos_par = len + {3'b000, addr_mode};
    wire [3:0] pos_stop = pos_par + {3'b000, par_en};
    wire maj = (votes_q[0] & votes_q[1]) | (votes_q[0] & rxd_i)
             | (votes_q[1] & rxd_i);  // RULE18
    wire in_bits = (rx_state_q == mps_pkg::MPS_RX_BITS);
    wire decide = in_bits & sample_clock_tick & (rx_ph_q == 3'd5);
    wire rx_done = decide & (rx_idx_q == pos_stop);
    wire [7:0] char_mask = 8'hFF >> (3'd7 - char_code);
    wire [7:0] rx_data = rx_frame_q[7:0] & char_mask;
    wire rx_addr_bit = rx_frame_q[len];
    wire par_calc = ~par_even ^ (^rx_data) ^ (addr_mode & rx_addr_bit);
    wire par_bad = par_en & (rx_frame_q[pos_par] != par_calc);
    wire addr_hit = addr_mode ? rx_addr_bit  // RULE21 RULE13
                              : gap_seen_q;  // RULE24
    wire take = rx_done & rx_en_q & (~sleep_q | addr_hit);  // RULE4 RULE3

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rx_state_q <= mps_pkg::MPS_RX_HUNT;
            rx_ph_q <= 3'h0;
            rx_idx_q <= 4'h0;
            rx_frame_q <= 11'h000;
            votes_q <= 2'b00;
        end else if (sample_clock_tick) begin
            case (rx_state_q)
                mps_pkg::MPS_RX_HUNT: begin
                    if (!rxd_i) begin
                        rx_state_q <= mps_pkg::MPS_RX_START;
                        rx_ph_q <= 3'h1;
                    end
                end
                mps_pkg::MPS_RX_START: begin
                    rx_ph_q <= rx_ph_q + 3'd1;
                    if (rxd_i && rx_ph_q <= PH_START) begin
                        rx_state_q <= mps_pkg::MPS_RX_HUNT;  // RULE17
                    end else if (rx_ph_q == PH_LAST) begin
                        rx_state_q <= mps_pkg::MPS_RX_BITS;
                        rx_idx_q <= 4'h0;
                    end
                end
                mps_pkg::MPS_RX_BITS: begin
                    rx_ph_q <= rx_ph_q + 3'd1;  // RULE16
                    if (rx_ph_q == 3'd3) begin
                        votes_q[0] <= rxd_i;
                    end
                    if (rx_ph_q == 3'd4) begin
                        votes_q[1] <= rxd_i;
                    end
                    if (rx_ph_q == 3'd5) begin
                        rx_frame_q[rx_idx_q] <= maj;
                        if (rx_idx_q == pos_stop) begin
                            rx_state_q <= mps_pkg::MPS_RX_HUNT;  // RULE23
                        end
                    end
                    if (rx_ph_q == PH_LAST) begin
                        rx_idx_q <= rx_idx_q + 4'd1;
                    end
                end
                default: begin
                    rx_state_q <= mps_pkg::MPS_RX_HUNT;
                end
            endcase
        end
    end

    // Idle gap watch for block starts
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            idle_cnt_q <= 7'h00;
            gap_seen_q <= 1'b0;
        end else begin
            if (!rxd_i || rx_state_q != mps_pkg::MPS_RX_HUNT) begin
                idle_cnt_q <= 7'h00;
            end else if (sample_clock_tick && idle_cnt_q != GAP_TICKS) begin
                idle_cnt_q <= idle_cnt_q + 7'd1;
            end
            if (rx_done) begin
                gap_seen_q <= 1'b0;
            end
            if (idle_cnt_q == GAP_TICKS) begin
                gap_seen_q <= 1'b1;  // RULE2
            end
        end
    end

    // ****************************************************************
    // Control and status registers
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            comm_control_reg_q <= `MPS_CCR_RST;
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            sleep_q <= 1'b0;
            rx_err_irq_en_q <= 1'b0;
            baud_q <= `MPS_BAUD_RST;
            tx_irq_en_q <= 1'b0;
            rx_break_irq_enable_q <= 1'b0;
        end else begin
            if (wr_ccr) begin
                comm_control_reg_q <= pwdata_i[7:0];
            end
            if (wr_ctl1) begin
                rx_en_q <= pwdata_i[`MPS_CTL1_RXEN];
                tx_en_q <= pwdata_i[`MPS_CTL1_TXEN];
                sleep_q <= pwdata_i[`MPS_CTL1_SLEEP];  // RULE20
                rx_err_irq_en_q <= pwdata_i[`MPS_CTL1_ERRIE];
            end
            if (wr_baud) begin
                baud_q <= pwdata_i[15:0];
            end
            if (wr_ctl2) begin
                tx_irq_en_q <= pwdata_i[`MPS_CTL2_TXIE];
                rx_break_irq_enable_q <= pwdata_i[`MPS_CTL2_RXIE];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rx_wake_flag_q <= 1'b0;
            par_err_q <= 1'b0;
            ovr_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            rx_char_ready_q <= 1'b0;
            rx_buf_q <= 8'h00;
        end else begin
            if (rd_rxbuf) begin
                rx_char_ready_q <= 1'b0;
            end
            if (wr_rxst) begin
                par_err_q <= par_err_q & ~pwdata_i[`MPS_RXST_PE];
                ovr_err_q <= ovr_err_q & ~pwdata_i[`MPS_RXST_OE];
                frm_err_q <= frm_err_q & ~pwdata_i[`MPS_RXST_FE];
            end
            if (rx_done && rx_en_q) begin
                rx_wake_flag_q <= addr_hit;
            end
            if (take) begin
                rx_char_ready_q <= 1'b1;
                rx_buf_q <= rx_data;
                par_err_q <= par_err_q | par_bad;
                frm_err_q <= frm_err_q | ~maj;
                ovr_err_q <= ovr_err_q | (rx_char_ready_q & ~rd_rxbuf);
            end
        end
    end

    assign rx_irq_o = (rx_break_irq_enable_q & rx_char_ready_q)  // RULE3
                    | (rx_err_irq_en_q & rx_err);

    // ****************************************************************
    // Transmit buffer and wake request
    // ****************************************************************
    mps_tx_if txi ();
    wire tx_ld = tx_full_q & tx_en_q & txi.rdy;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tx_buffer_reg_q <= 8'h00;
            tx_full_q <= 1'b0;
            tx_wake_request_q <= 1'b0;
        end else begin
            if (tx_ld) begin
                tx_full_q <= 1'b0;  // RULE10
                tx_wake_request_q <= 1'b0;  // RULE9
            end
            if (wr_ctl1) begin
                tx_wake_request_q <= pwdata_i[`MPS_CTL1_WAKE];
            end
            if (wr_txbuf) begin
                tx_buffer_reg_q <= pwdata_i[7:0];
                tx_full_q <= 1'b1;
            end
        end
    end

    assign ctl2_rd = {~tx_full_q, ~tx_full_q & ~txi.busy, 4'h0,
                      rx_break_irq_enable_q, tx_irq_en_q};
    assign tx_irq_o = tx_irq_en_q & ~tx_full_q;

    assign txi.tick = sample_clock_tick;
    assign txi.ld = tx_ld;
    assign txi.data = tx_buffer_reg_q;
    assign txi.wake = tx_wake_request_q;
    assign txi.char_code = char_code;
    assign txi.addr_mode = addr_mode;
    assign txi.par_en = par_en;
    assign txi.par_even = par_even;
    assign txi.two_stop = comm_control_reg_q[`MPS_CCR_STOP2];

    mps_tx u_tx (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .txi(txi)
    );

    assign txd_o = txi.line;
endmodule : mps_serial

// [hdl/mps_tx.sv]
// Transmit shifter with wake latch
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_tx (
    input wire logic clock_i,    // System clock
    input wire logic srst_i,     // Synchronous reset
    mps_tx_if.sh txi             // Load port from register side
);
    localparam logic [2:0] PH_LAST = 3'(`MPS_BIT_TICKS - 1);
    localparam logic [3:0] GAP_N = 4'(`MPS_WAKE_IDLE_BITS);

    mps_pkg::mps_tx_state_t state_q;
    logic [12:0] tx_shift_reg_q;
    logic [12:0] vec;
    logic [3:0] idx_q;
    logic [3:0] n_q;
    logic [3:0] n_d;
    logic [3:0] p;
    logic [2:0] ph_q;
    logic wake_temp_latch_q;
    logic line_q;
    logic par;
    logic gap;

    // ****************************************************************
    // Frame assembly, start bit first
    // ****************************************************************
    assign gap = txi.wake & ~txi.addr_mode;
    always_comb begin
        vec = '1;
        par = ~txi.par_even ^ (txi.addr_mode & txi.wake);  // RULE22
        vec[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= txi.char_code) begin
                vec[i + 1] = txi.data[i];
                par = par ^ txi.data[i];
            end
        end
        p = {1'b0, txi.char_code} + 4'd2;
        if (txi.addr_mode) begin
            vec[p] = txi.wake;  // RULE11 RULE12
            p = p + 4'd1;
        end
        if (txi.par_en) begin
            vec[p] = par;
            p = p + 4'd1;
        end
        n_d = p + {3'b000, txi.two_stop};  // RULE15
        if (gap) begin
            vec = '1;  // RULE8
            n_d = GAP_N - 4'd1;
        end
    end

    // ****************************************************************
    // Shifter
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= mps_pkg::MPS_TX_IDLE;
            tx_shift_reg_q <= '1;
            idx_q <= 4'h0;
            n_q <= 4'h0;
            ph_q <= 3'h0;
            wake_temp_latch_q <= 1'b0;
            line_q <= 1'b1;
        end else if (state_q == mps_pkg::MPS_TX_IDLE) begin
            line_q <= 1'b1;  // RULE23
            if (txi.ld) begin
                state_q <= mps_pkg::MPS_TX_SEND;
                tx_shift_reg_q <= vec;
                wake_temp_latch_q <= txi.wake;  // RULE9
                n_q <= n_d;
                idx_q <= 4'h0;
                ph_q <= 3'h0;
                line_q <= vec[0];
            end
        end else if (txi.tick) begin
            ph_q <= ph_q + 3'd1;  // RULE16
            if (ph_q == PH_LAST) begin
                idx_q <= idx_q + 4'd1;
                line_q <= tx_shift_reg_q[idx_q + 4'd1] | (wake_temp_latch_q & ~txi.addr_mode);  // RULE8
                if (idx_q == n_q) begin
                    state_q <= mps_pkg::MPS_TX_IDLE;
                    line_q <= 1'b1;
                end
            end
        end
    end

    assign txi.rdy = (state_q == mps_pkg::MPS_TX_IDLE);
    assign txi.busy = (state_q == mps_pkg::MPS_TX_SEND);
    assign txi.line = line_q;
endmodule : mps_tx

// [include/mps_params.svh]
// Serial port constants
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MPS_OFS_CCR 8'h00
`define MPS_OFS_CTL1 8'h04
`define MPS_OFS_BAUD 8'h08
`define MPS_OFS_CTL2 8'h0C
`define MPS_OFS_RXST 8'h10
`define MPS_OFS_RXBUF 8'h14
`define MPS_OFS_TXBUF 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define MPS_CCR_MODE 3
`define MPS_CCR_PEN 5
`define MPS_CCR_EVEN 6
`define MPS_CCR_STOP2 7
`define MPS_CTL1_RXEN 0
`define MPS_CTL1_TXEN 1
`define MPS_CTL1_SLEEP 2
`define MPS_CTL1_WAKE 3
`define MPS_CTL1_ERRIE 6
`define MPS_CTL2_TXIE 0
`define MPS_CTL2_RXIE 1
`define MPS_RXST_WAKE 1
`define MPS_RXST_PE 2
`define MPS_RXST_OE 3
`define MPS_RXST_FE 4
`define MPS_RXST_RDY 6
`define MPS_RXST_ERR 7

// ****************************************************************
// Timing and resets
// ****************************************************************
`define MPS_CCR_RST 8'h07
`define MPS_BAUD_RST 16'h0000
`define MPS_BIT_TICKS 8
`define MPS_START_TICKS 4
`define MPS_GAP_BITS 10
`define MPS_WAKE_IDLE_BITS 11

`endif

// [include/mps_pkg.sv]
// Serial port types
package mps_pkg;
    typedef enum logic [1:0] {
        MPS_RX_HUNT = 2'b00,
        MPS_RX_START = 2'b01,
        MPS_RX_BITS = 2'b10
    } mps_rx_state_t;

    typedef enum logic {
        MPS_TX_IDLE = 1'b0,
        MPS_TX_SEND = 1'b1
    } mps_tx_state_t;
endpackage : mps_pkg

// [include/mps_tx_if.sv]
// Register side to transmit shifter
`timescale 1ns/1ps
interface mps_tx_if;
    logic tick;
    logic ld;
    logic [7:0] data;
    logic wake;
    logic [2:0] char_code;
    logic addr_mode;
    logic par_en;
    logic par_even;
    logic two_stop;
    logic rdy;
    logic busy;
    logic line;
    modport ctl (output tick, ld, data, wake, char_code, addr_mode, par_en,
                 par_even, two_stop, input rdy, busy, line);
    modport sh (input tick, ld, data, wake, char_code, addr_mode, par_en,
                par_even, two_stop, output rdy, busy, line);
endinterface : mps_tx_if

// [verification/mps_remote.sv]
// Remote node on the shared line
`timescale 1ns/1ps
module mps_remote (
    input wire logic clock_i, // Clock
    input wire logic txd_i,   // Port's transmit line
    output logic rxd_o        // Port's receive line
);
    initial rxd_o = 1'b1;
    // Frame out, LSB first; gl flips one tick of each data bit
    task automatic send(input logic [9:0] b, input int n, input bit gl);
        for (int i = 0; i <= n + 1; i++) begin
            for (int t = 0; t < 8; t++) begin
                @(posedge clock_i);
                rxd_o <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : b[i-1] ^ (gl && t == 3);
            end
        end
    endtask : send
    task automatic fake_start(input int k);
        repeat (k) @(posedge clock_i) rxd_o <= 1'b0;
        @(posedge clock_i) rxd_o <= 1'b1;
    endtask : fake_start
    task automatic recv(output logic [9:0] b, input int n, output logic stp);
        b = 10'h000;
        while (txd_i !== 1'b0) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge clock_i);
            b[i] = txd_i;
        end
        repeat (8) @(posedge clock_i);
        stp = txd_i;
    endtask : recv
endmodule : mps_remote

// [verification/mps_serial_assertions.sv]
// Checks on the serial port pins
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_serial_assertions (
    input wire logic clock_i,         // Clock
    input wire logic srst_i,          // Reset
    input wire logic psel_i,          // Select
    input wire logic penable_i,       // Enable
    input wire logic pwrite_i,        // Write
    input wire logic [7:0] paddr_i,   // Address
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pready_o,        // Ready
    input wire logic pslverr_o,       // Error
    input wire logic rxd_i,           // Serial in
    input wire logic txd_o,           // Serial out
    input wire logic rx_irq_o,        // Receive request
    input wire logic tx_irq_o         // Transmit request
);
    logic [7:0] ccr_q;
    wire acc = psel_i && penable_i;
    wire mapped = (paddr_i <= `MPS_OFS_TXBUF) && (paddr_i[1:0] == 2'b00);
    wire ccr_wr = acc && pwrite_i && (paddr_i == `MPS_OFS_CCR);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ccr_q <= `MPS_CCR_RST;
        end else if (ccr_wr) begin
            ccr_q <= pwdata_i[7:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // Spans assume a tick every clock
    chk_idle_after_reset: assert property ($fell(srst_i) |-> txd_o && !tx_irq_o && !rx_irq_o)
        else $error("not idle after reset");
    chk_bit_span: assert property ($changed(txd_o) |=> $stable(txd_o) [*7])
        else $error("bit too short");
    chk_stop_high: assert property ($fell(txd_o) |-> ##[1:96] txd_o)
        else $error("no stop bit");
    chk_mode_readback: assert property (acc && !pwrite_i && paddr_i == `MPS_OFS_CCR
        |-> (prdata_o[7:0] & 8'hEF) == (ccr_q & 8'hEF))
        else $error("format readback");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped not refused");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr_o)
        else $error("mapped access refused");
    chk_read_idle: assert property (!acc |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("data outside access");
    chk_ready_access: assert property (acc |-> pready_o)
        else $error("ready low");
    chk_upper_zero: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("upper bits set");
endmodule : mps_serial_assertions

// [verification/multiproc_async_serial_bench.sv]
// Bench for the serial port
`timescale 1ns/1ps
`include "mps_params.svh"
module multiproc_async_serial_bench;
    logic clock_i, srst_i, psel, penable, pwrite, rxd, txd, pready, pslverr, e, stp;
    logic rx_irq, tx_irq, p;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, d;
    logic [9:0] b;
    logic [7:0] cfg [3] = '{8'h07, 8'h66, 8'hA4};
    int fails = 0, total_checks = 0, cyc = 0, seed = 32'hd4ad, n, t0, t1;
    int q[$];
    mps_serial mps_serial_i (.clock_i(clock_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd),
        .txd_o(txd), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
    mps_remote mps_remote_i (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("unexpected %0t: %h vs %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic poll(input logic [7:0] a, input int bt);
        r = 32'h0;
        for (int i = 0; i < 60 && r[bt] !== 1'b1; i++) apb(1'b0, a, 32'h0);
    endtask : poll
    function automatic logic par(input logic [8:0] v, input logic ev);
        return ev ? ^v : ~^v;
    endfunction : par
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        srst_i = 1'b1;
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        apb(1'b0, `MPS_OFS_CCR, 32'h0);
        chk(r, 32'h07);
        apb(1'b0, `MPS_OFS_CTL1, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk(r, 0);
        chk(e, 1);
        $display("test reset done");
        foreach (cfg[k]) begin
            n = cfg[k][2:0] + 1;
            apb(1'b1, `MPS_OFS_CCR, cfg[k]);
            apb(1'b1, `MPS_OFS_CTL1, 32'h03);
            d = $random(seed) & ((1 << n) - 1);
            p = par(d[8:0], cfg[k][6]);
            fork
                mps_remote_i.recv(b, n + cfg[k][5], stp);
                apb(1'b1, `MPS_OFS_TXBUF, d);
            join
            chk(32'(b) & ((1 << n) - 1), d);
            if (cfg[k][5]) chk(b[n], p);
            chk(stp, 1'b1);
            q.push_back(d);
            mps_remote_i.send(d[9:0] | (10'(p) << n), n + cfg[k][5], k == 1);
            poll(`MPS_OFS_RXST, 6);
            apb(1'b0, `MPS_OFS_RXBUF, 32'h0);
            chk(r, q.pop_front());
        end
        $display("test formats done");
        mps_remote_i.fake_start(3);
        repeat (100) @(posedge clock_i);
        apb(1'b0, `MPS_OFS_RXST, 32'h0);
        chk(r[6], 1'b0);
        $display("test start reject done");
        apb(1'b1, `MPS_OFS_CCR, 32'h0F);
        apb(1'b1, `MPS_OFS_CTL2, 32'h02);
        apb(1'b1, `MPS_OFS_CTL1, 32'h07);
        mps_remote_i.send(10'h05A, 9, 1'b0);
        repeat (10) @(posedge clock_i);
        apb(1'b0, `MPS_OFS_RXST, 32'h0);
        chk({r[6], rx_irq}, 2'b00);
        mps_remote_i.send(10'h1A5, 9, 1'b0);
        repeat (10) @(posedge clock_i);
        apb(1'b0, `MPS_OFS_RXST, 32'h0);
        chk({r[6], r[1], rx_irq}, 3'b111);
        apb(1'b0, `MPS_OFS_CTL1, 32'h0);
        chk(r[2], 1'b1);
        apb(1'b0, `MPS_OFS_RXBUF, 32'h0);
        chk(r, 32'hA5);
        $display("test address sleep done");
        apb(1'b1, `MPS_OFS_CTL1, 32'h0B);
        fork
            begin
                mps_remote_i.recv(b, 9, stp);
                chk(b, 10'h133);
                mps_remote_i.recv(b, 9, stp);
                chk(b, 10'h044);
            end
            begin
                apb(1'b1, `MPS_OFS_TXBUF, 32'h33);
                apb(1'b0, `MPS_OFS_CTL1, 32'h0);
                chk(r[3], 1'b0);
                apb(1'b0, `MPS_OFS_CTL2, 32'h0);
                chk(r[7], 1'b1);
                apb(1'b1, `MPS_OFS_TXBUF, 32'h44);
            end
        join
        $display("test address send done");
        apb(1'b1, `MPS_OFS_CCR, 32'h07);
        apb(1'b1, `MPS_OFS_CTL1, 32'h0A);
        fork
            mps_remote_i.recv(b, 8, stp);
            begin
                @(negedge txd);
                t1 = cyc;
            end
            begin
                apb(1'b1, `MPS_OFS_TXBUF, 32'hEE);
                t0 = cyc;
                poll(`MPS_OFS_CTL2, 7);
                apb(1'b1, `MPS_OFS_TXBUF, 32'h5C);
            end
        join
        chk(b, 10'h05C);
        chk((t1 - t0 >= 88) && (t1 - t0 <= 96), 1'b1);
        $display("test idle wake send done");
        apb(1'b1, `MPS_OFS_CTL1, 32'h05);
        mps_remote_i.send(10'h011, 8, 1'b0);
        mps_remote_i.send(10'h022, 8, 1'b0);
        repeat (10) @(posedge clock_i);
        apb(1'b0, `MPS_OFS_RXBUF, 32'h0);
        chk(r, 32'h11);
        apb(1'b0, `MPS_OFS_RXST, 32'h0);
        chk(r[6], 1'b0);
        repeat (100) @(posedge clock_i);
        mps_remote_i.send(10'h033, 8, 1'b0);
        repeat (10) @(posedge clock_i);
        apb(1'b0, `MPS_OFS_RXBUF, 32'h0);
        chk(r, 32'h33);
        $display("test idle gap receive done");
        tally_and_finish();
    end
endmodule : multiproc_async_serial_bench
bind mps_serial mps_serial_assertions mps_serial_assertions_i (.*);
